// File: verilog/diag_params_defs.vh
// register offsets, field values, reset values and timing counts
// for the option module diagnostic parameter block
`ifndef DIAG_PARAMS_DEFS_VH
`define DIAG_PARAMS_DEFS_VH

// register byte offsets on the AHB-Lite bus
`define OFF_MODULE_TYPE_ID 8'h00
`define OFF_FW_MAJOR 8'h04
`define OFF_FW_MINOR 8'h08
`define OFF_BIT_RATE_SELECT 8'h0c
`define OFF_SERIAL 8'h10
`define OFF_NETWORK_HEALTH 8'h14
`define OFF_IRQ_STATUS 8'h18
`define OFF_IRQ_MASK 8'h1c
`define OFF_SOFT_RESET 8'h20
`define OFF_FAULT_CODE 8'h24

// bit-rate selector codes
`define RATE_DISABLED 8'hfe
`define RATE_AUTO 8'hff
`define RATE_MAX_CODE 8'h08
`define RATE_DEFAULT 8'h05

// network health codes (16-bit two's complement)
`define HEALTH_NO_ACK 16'hffff
`define HEALTH_HW_FAIL 16'hfffe
`define HEALTH_CFG_ERR 16'hfffd
`define HEALTH_SW_ERR 16'hfffc
`define HEALTH_AUTO 16'hfff8
`define HEALTH_BUS_OFF 16'hfff6
`define HEALTH_MAX_RATE 16'h270f

// fault code on bus off
`define FAULT_BUS_OFF 8'h42

// interrupt status bits
`define IRQ_BUS_OFF 0
`define IRQ_AUTO_DONE 1
`define IRQ_BAD_RATE 2
`define IRQ_WINDOW 3
`define IRQ_WIDTH 4

// measurement window
`define CLK_HZ 50000000
`define WINDOW_MS 1000
`define WINDOW_CYCLES ((`CLK_HZ / 1000) * `WINDOW_MS)

`endif

// File: verilog/rate_table.v
// bit-rate code to bit-time lookup, registered output
// assumes one clock; code valid 0..8, others give zero
`timescale 1ns/100ps
`default_nettype none
module rate_table (
	// clock
	input wire hclk,
	// lookup
	input wire [7:0] code,
	output reg [15:0] bit_cycles
);

	// bit times in 50 MHz cycles
	always @(posedge hclk) begin
		case (code)
			8'h00: bit_cycles <= 16'h0032;
			8'h01: bit_cycles <= 16'h003e;
			8'h02: bit_cycles <= 16'h0064;
			8'h03: bit_cycles <= 16'h00c8;
			8'h04: bit_cycles <= 16'h0190;
			8'h05: bit_cycles <= 16'h01f4;
			8'h06: bit_cycles <= 16'h03e8;
			8'h07: bit_cycles <= 16'h09c4;
			8'h08: bit_cycles <= 16'h1388;
			default: bit_cycles <= 16'h0000;
		endcase
	end

endmodule
`default_nettype wire

// File: verilog/diag_params.v
// diagnostic and configuration parameter block of a CAN option module
// assumes an AHB-Lite master with single word transfers and a CAN core
// that reports frame, ack, bus-off and detection events as pulses
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "diag_params_defs.vh"
module diag_params #(
	parameter [15:0] MODULE_TYPE = 16'h0abc,
	parameter [15:0] FW_MAJOR = 16'h0065,
	parameter [7:0] FW_MINOR = 8'h05,
	parameter [31:0] SERIAL = 32'h0001e240,
	parameter [31:0] WINDOW_CYCLES = `WINDOW_CYCLES
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	// can core status
	input wire frame_done,
	input wire ack_missing,
	input wire ack_seen,
	input wire bus_off,
	input wire init_fail,
	input wire fw_fault,
	input wire detect_done,
	input wire [7:0] detect_code,
	// can core control
	output reg can_enable,
	output reg detect_run,
	output reg [15:0] bit_cycles_out,
	output reg slot_user_trip,
	output reg irq
);

	localparam [3:0] ST_RESET = 4'b0001;
	localparam [3:0] ST_DETECT = 4'b0010;
	localparam [3:0] ST_RUN = 4'b0100;
	localparam [3:0] ST_OFF = 4'b1000;

	function valid_code;
		input [7:0] c;
		begin
			valid_code = (c <= `RATE_MAX_CODE) || (c == `RATE_AUTO) || (c == `RATE_DISABLED);
		end
	endfunction

	reg [3:0] state_reg;
	reg [7:0] bit_rate_select_reg;
	reg [7:0] active_rate_reg;
	reg [15:0] network_health_reg;
	reg [7:0] fault_code_reg;
	reg [15:0] frame_cnt_reg;
	reg [31:0] window_cnt_reg;
	reg no_ack_reg;
	reg bus_off_reg;
	reg cfg_err_reg;
	reg [`IRQ_WIDTH-1:0] irq_status_reg;
	reg [`IRQ_WIDTH-1:0] irq_mask_reg;
	reg soft_reset_reg;
	reg wr_pend_reg;
	reg rd_pend_reg;
	reg [7:0] addr_reg;
	wire [15:0] bit_cycles;
	wire window_end;
	wire take;
	wire wr_sel;
	wire [`IRQ_WIDTH-1:0] irq_events;
	reg [31:0] rd_mux;

	rate_table u_rate_table (
		.hclk(hclk),
		.code(active_rate_reg),
		.bit_cycles(bit_cycles)
	);

	assign take = hsel && hready && htrans[1];
	assign wr_sel = wr_pend_reg;
	assign window_end = (window_cnt_reg == WINDOW_CYCLES - 32'h1);

	// bus address phase capture; zero wait states
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready) begin
				wr_pend_reg <= take && hwrite;
				rd_pend_reg <= take && !hwrite;
				addr_reg <= haddr[7:0];
			end
		end
	end

	// read mux, unmapped reads as zero
	always @* begin
		case (haddr[7:0])
			`OFF_MODULE_TYPE_ID: rd_mux = {16'h0000, MODULE_TYPE};
			`OFF_FW_MAJOR: rd_mux = {16'h0000, FW_MAJOR};
			`OFF_FW_MINOR: rd_mux = {24'h000000, FW_MINOR};
			`OFF_BIT_RATE_SELECT: rd_mux = {24'h000000, bit_rate_select_reg};
			`OFF_SERIAL: rd_mux = SERIAL;
			`OFF_NETWORK_HEALTH: rd_mux = {16'h0000, network_health_reg};
			`OFF_IRQ_STATUS: rd_mux = {28'h0000000, irq_status_reg};
			`OFF_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_reg};
			`OFF_FAULT_CODE: rd_mux = {24'h000000, fault_code_reg};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// read data registered at the address phase, valid in data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (take && !hwrite) begin
			hrdata <= rd_mux;
		end
	end

	// selector register; written value checked, rate used after reset
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_rate_select_reg <= `RATE_DEFAULT;
			cfg_err_reg <= 1'b0;
		end else if (wr_sel && addr_reg == `OFF_BIT_RATE_SELECT) begin
			if (valid_code(hwdata[7:0])) begin
				bit_rate_select_reg <= hwdata[7:0];
				cfg_err_reg <= 1'b0;
			end else begin
				bit_rate_select_reg <= `RATE_DEFAULT;
				cfg_err_reg <= 1'b1;
			end
		end else if (state_reg == ST_DETECT && detect_done && detect_code <= `RATE_MAX_CODE) begin
			bit_rate_select_reg <= detect_code;
		end
	end

	// soft reset pulse and interrupt mask
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			soft_reset_reg <= 1'b0;
			irq_mask_reg <= {`IRQ_WIDTH{1'b0}};
		end else begin
			soft_reset_reg <= wr_sel && addr_reg == `OFF_SOFT_RESET && hwdata[0];
			if (wr_sel && addr_reg == `OFF_IRQ_MASK) begin
				irq_mask_reg <= hwdata[`IRQ_WIDTH-1:0];
			end
		end
	end

	assign irq_events = {window_end, wr_sel && addr_reg == `OFF_BIT_RATE_SELECT && !valid_code(hwdata[7:0]),
		state_reg == ST_DETECT && detect_done, state_reg == ST_RUN && bus_off};

	// sticky status, set wins over write-one clear
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status_reg <= {`IRQ_WIDTH{1'b0}};
			irq <= 1'b0;
		end else begin
			if (wr_sel && addr_reg == `OFF_IRQ_STATUS) begin
				irq_status_reg <= (irq_status_reg & ~hwdata[`IRQ_WIDTH-1:0]) | irq_events;
			end else begin
				irq_status_reg <= irq_status_reg | irq_events;
			end
			irq <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// link state: rate applied on reset and at the end of detection
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_RESET;
			active_rate_reg <= `RATE_DEFAULT;
			bus_off_reg <= 1'b0;
			no_ack_reg <= 1'b0;
			fault_code_reg <= 8'h00;
			slot_user_trip <= 1'b0;
		end else begin
			case (state_reg)
				ST_RESET: begin
					bus_off_reg <= 1'b0;
					no_ack_reg <= 1'b0;
					if (bit_rate_select_reg == `RATE_DISABLED) begin
						state_reg <= ST_OFF;
					end else if (bit_rate_select_reg == `RATE_AUTO) begin
						state_reg <= ST_DETECT;
					end else begin
						active_rate_reg <= bit_rate_select_reg;
						state_reg <= ST_RUN;
					end
				end
				ST_DETECT: begin
					if (detect_done && detect_code <= `RATE_MAX_CODE) begin
						active_rate_reg <= detect_code;
						state_reg <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (bus_off) begin
						bus_off_reg <= 1'b1;
						fault_code_reg <= `FAULT_BUS_OFF;
						slot_user_trip <= 1'b1;
					end
					if (ack_missing) begin
						no_ack_reg <= 1'b1;
					end else if (ack_seen) begin
						no_ack_reg <= 1'b0;
					end
				end
				ST_OFF: begin
					state_reg <= ST_OFF;
				end
				default: state_reg <= ST_RESET;
			endcase
			if (soft_reset_reg) begin
				state_reg <= ST_RESET;
				slot_user_trip <= 1'b0;
			end
		end
	end

	// core controls
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			can_enable <= 1'b0;
			detect_run <= 1'b0;
			bit_cycles_out <= 16'h0000;
		end else begin
			can_enable <= (state_reg == ST_RUN) && !bus_off_reg;
			detect_run <= (state_reg == ST_DETECT);
			bit_cycles_out <= bit_cycles;
		end
	end

	// frame rate window
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			window_cnt_reg <= 32'h00000000;
			frame_cnt_reg <= 16'h0000;
		end else begin
			if (window_end) begin
				window_cnt_reg <= 32'h00000000;
				frame_cnt_reg <= {15'h0000, frame_done};
			end else begin
				window_cnt_reg <= window_cnt_reg + 32'h1;
				if (frame_done && frame_cnt_reg != `HEALTH_MAX_RATE) begin
					frame_cnt_reg <= frame_cnt_reg + 16'h1;
				end
			end
		end
	end

	// network health, errors take priority over rate
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			network_health_reg <= 16'h0000;
		end else if (fw_fault) begin
			network_health_reg <= `HEALTH_SW_ERR;
		end else if (init_fail) begin
			network_health_reg <= `HEALTH_HW_FAIL;
		end else if (cfg_err_reg) begin
			network_health_reg <= `HEALTH_CFG_ERR;
		end else if (bus_off_reg) begin
			network_health_reg <= `HEALTH_BUS_OFF;
		end else if (state_reg == ST_DETECT) begin
			network_health_reg <= `HEALTH_AUTO;
		end else if (no_ack_reg) begin
			network_health_reg <= `HEALTH_NO_ACK;
		end else if (window_end) begin
			network_health_reg <= frame_cnt_reg;
		end else if (network_health_reg[15]) begin
			network_health_reg <= 16'h0000;
		end
	end

endmodule
`default_nettype wire

// File: testbench/diag_params_asserts.sv
// port checker for the diagnostic parameter block
// bound to every diag_params instance, one clock domain
`timescale 1ns/100ps
`default_nettype none
module diag_params_asserts (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus answer
	input wire logic hreadyout,
	input wire logic hresp,
	// node side
	input wire logic bus_off,
	input wire logic detect_done,
	input wire logic can_enable,
	input wire logic detect_run,
	input wire logic [15:0] bit_cycles_out,
	input wire logic slot_user_trip
);
	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_run;
		can_enable && bit_cycles_out inside {[16'd50:16'd5000]};
	endsequence
	sequence s_off;
		!can_enable && !detect_run;
	endsequence
	property p_ready;
		hreadyout && !hresp;
	endproperty
	a_ready: assert property (p_ready) else $error("bus answer not zero wait okay");
	property p_dflt;
		$rose(hresetn) |-> ##[1:3] (can_enable && bit_cycles_out == 16'd500);
	endproperty
	a_dflt: assert property (p_dflt) else $error("default rate not running");
	property p_range;
		can_enable |-> s_run;
	endproperty
	a_range: assert property (p_range) else $error("bit time out of range");
	property p_hold;
		can_enable && $past(can_enable) && $past(can_enable, 2) |-> $stable(bit_cycles_out);
	endproperty
	a_hold: assert property (p_hold) else $error("rate changed while running");
	property p_boff;
		bus_off && can_enable |-> ##[1:3] s_off;
	endproperty
	a_boff: assert property (p_boff) else $error("node stays on after bus off");
	property p_trip;
		bus_off && can_enable |-> ##[1:3] slot_user_trip;
	endproperty
	a_trip: assert property (p_trip) else $error("no trip after bus off");
	property p_det;
		detect_run && detect_done |-> ##[1:4] s_run;
	endproperty
	a_det: assert property (p_det) else $error("found rate not used");
	property p_excl;
		!(can_enable && detect_run);
	endproperty
	a_excl: assert property (p_excl) else $error("running during detection");
endmodule
bind diag_params diag_params_asserts diag_params_asserts_i (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .bus_off(bus_off), .detect_done(detect_done),
	.can_enable(can_enable), .detect_run(detect_run), .bit_cycles_out(bit_cycles_out),
	.slot_user_trip(slot_user_trip));
`default_nettype wire

// File: testbench/can_net_model.sv
// other nodes on the network, seen as core event pulses
// frame every 10 cycles while enabled, detection takes 40 cycles
`timescale 1ns/100ps
`default_nettype none
module can_net_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// node control
	input wire logic can_enable,
	input wire logic detect_run,
	// scenario knobs
	input wire logic [7:0] net_code,
	input wire logic no_ack,
	// node events
	output logic frame_done,
	output logic ack_seen,
	output logic ack_missing,
	output logic detect_done,
	output logic [7:0] detect_code
);
	logic [5:0] cnt;
	// detection time counted from the start of each detection run
	logic [5:0] dcnt;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 6'h00;
			dcnt <= 6'h00;
			{frame_done, ack_seen, ack_missing, detect_done} <= 4'h0;
			detect_code <= 8'h00;
		end else begin
			cnt <= (cnt == 6'h27) ? 6'h00 : cnt + 6'h01;
			frame_done <= can_enable && (cnt % 10 == 0);
			ack_seen <= can_enable && !no_ack && cnt == 6'h01;
			ack_missing <= can_enable && no_ack && cnt == 6'h01;
			dcnt <= detect_run ? dcnt + 6'h01 : 6'h00;
			detect_done <= detect_run && dcnt == 6'h27;
			// code only valid with the pulse
			detect_code <= (detect_run && dcnt == 6'h27) ? net_code : ~detect_code;
		end
	end
endmodule
`default_nettype wire

// File: testbench/test_diag_params.sv
// self-checking bench for the diagnostic parameter block
// assumes one 50 MHz clock and a 100 cycle window
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_diag_params;
	localparam logic [15:0] TYPE_ID = 16'h0123; // arbitrary value
	localparam logic [31:0] SN = 32'h0001e240;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, can_enable, detect_run, slot_user_trip, irq;
	logic frame_done, ack_seen, ack_missing, detect_done, bus_off, init_fail, fw_fault, no_ack, rd_pend, pin_go;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, g;
	logic [7:0] detect_code;
	logic [15:0] bit_cycles_out, p;
	logic [34:0] q[$];
	logic [34:0] e;
	logic [15:0] bits[9] = '{16'd50, 16'd0, 16'd100, 16'd200, 16'd400, 16'd500, 16'd1000, 16'd2500, 16'd5000};
	int n_errors = 0;
	int checks_done = 0;
	int code, r, n;
	diag_params #(.MODULE_TYPE(TYPE_ID), .FW_MAJOR(16'h0065), .FW_MINOR(8'h05), .SERIAL(SN),
		.WINDOW_CYCLES(100)) diag_params_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frame_done(frame_done),
		.ack_missing(ack_missing), .ack_seen(ack_seen), .bus_off(bus_off), .init_fail(init_fail),
		.fw_fault(fw_fault), .detect_done(detect_done), .detect_code(detect_code), .can_enable(can_enable),
		.detect_run(detect_run), .bit_cycles_out(bit_cycles_out), .slot_user_trip(slot_user_trip), .irq(irq));
	can_net_model can_net_model_i (.hclk(hclk), .hresetn(hresetn), .can_enable(can_enable),
		.detect_run(detect_run), .net_code(8'h02), .no_ack(no_ack), .frame_done(frame_done),
		.ack_seen(ack_seen), .ack_missing(ack_missing), .detect_done(detect_done), .detect_code(detect_code));
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	// oldest note against the output it names
	always @(posedge hclk) begin
		if ((rd_pend && hreadyout) || pin_go) begin
			e = q.pop_front();
			case (e[34:32])
				3'd0: g = hrdata;
				3'd1: g = {16'h0000, bit_cycles_out};
				3'd2: g = {31'h0, can_enable};
				3'd3: g = {31'h0, slot_user_trip};
				3'd4: g = {31'h0, irq};
				3'd5: g = {31'h0, detect_run};
				3'd6: g = {16'h0000, hrdata[15:0]};
				default: g = {24'h000000, hrdata[7:0]};
			endcase
			`CHK(g, e[31:0])
		end
	end
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge hclk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
		{hsel, htrans, hwdata, rd_pend} <= {1'b0, 2'b00, d, !w};
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
		rd_pend <= 1'b0;
		if (k >= 50) begin
			n_errors++;
			print_verdict();
		end
	endtask
	task automatic rd(input logic [2:0] s, input logic [7:0] a, input logic [31:0] x);
		q.push_back({s, x});
		bus(1'b0, a, 32'h0);
	endtask
	task automatic pin(input logic [2:0] s, input logic [31:0] x);
		q.push_back({s, x});
		@(posedge hclk);
		pin_go <= 1'b1;
		@(posedge hclk);
		pin_go <= 1'b0;
	endtask
	task automatic srst;
		bus(1'b1, 8'h20, 32'h1);
		repeat (6) @(posedge hclk);
	endtask
	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, bus_off, init_fail, fw_fault, no_ack, rd_pend, pin_go, htrans, haddr, hwdata} = '0;
		r = $urandom(32'h217d2268);
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rd(3'd6, 8'h00, {16'h0, TYPE_ID});
		rd(3'd6, 8'h04, 32'h65);
		rd(3'd7, 8'h08, 32'h05);
		bus(1'b1, 8'h10, ~SN);
		rd(3'd0, 8'h10, SN);
		rd(3'd0, 8'h30, 32'h0);
		repeat (250) @(posedge hclk);
		rd(3'd6, 8'h14, 32'd10);
		$display("test identity and frame rate done");
		r = $urandom % 9;
		p = 16'd500;
		for (int i = 0; i < 9; i++) begin
			code = (i + r) % 9;
			bus(1'b1, 8'h0c, 32'(code));
			if (p != 0) pin(3'd1, {16'h0, p});
			rd(3'd7, 8'h0c, 32'(code));
			srst();
			p = bits[code];
			if (p != 0) pin(3'd1, {16'h0, p});
		end
		$display("test rate codes done");
		bus(1'b1, 8'h0c, 32'(9 + $urandom % 244));
		rd(3'd7, 8'h0c, 32'h5);
		rd(3'd6, 8'h14, 32'hfffd);
		pin(3'd4, 32'h0);
		bus(1'b1, 8'h1c, 32'h4);
		pin(3'd4, 32'h1);
		bus(1'b1, 8'h18, 32'h4);
		pin(3'd4, 32'h0);
		bus(1'b1, 8'h1c, 32'h0);
		$display("test refused rate done");
		bus(1'b1, 8'h0c, 32'hff);
		srst();
		pin(3'd5, 32'h1);
		rd(3'd6, 8'h14, 32'hfff8);
		for (n = 0; n < 90 && detect_run !== 1'b0; n++) @(posedge hclk);
		if (n >= 90) begin
			n_errors++;
			print_verdict();
		end
		pin(3'd5, 32'h0);
		rd(3'd7, 8'h0c, 32'h02);
		pin(3'd1, 32'd100);
		bus(1'b1, 8'h0c, 32'hfe);
		srst();
		repeat (40) @(posedge hclk);
		pin(3'd2, 32'h0);
		pin(3'd5, 32'h0);
		$display("test detect and disable done");
		bus(1'b1, 8'h0c, 32'h5);
		srst();
		no_ack <= 1'b1;
		repeat (50) @(posedge hclk);
		rd(3'd6, 8'h14, 32'hffff);
		{no_ack, init_fail} <= 2'b01;
		rd(3'd6, 8'h14, 32'hfffe);
		{init_fail, fw_fault} <= 2'b01;
		rd(3'd6, 8'h14, 32'hfffc);
		fw_fault <= 1'b0;
		repeat (50) @(posedge hclk);
		bus_off <= 1'b1;
		@(posedge hclk);
		bus_off <= 1'b0;
		repeat (3) @(posedge hclk);
		pin(3'd3, 32'h1);
		pin(3'd2, 32'h0);
		rd(3'd7, 8'h24, 32'h42);
		rd(3'd6, 8'h14, 32'hfff6);
		srst();
		pin(3'd3, 32'h0);
		$display("test health codes done");
		print_verdict();
	end
endmodule
`default_nettype wire
